// file: idh_far_model.sv
// Far side model: ISA requesters and PC/PCI agents facing the handshake block.
// Assumes the bench says who wants service; withdraw is a commanded misbehaviour.
`timescale 1ns/10ps
`default_nettype none
module idh_far_model
  import idh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench control
  input wire logic [NCH-1:0] want,
  input wire logic [NPC-1:0] pc_want,
  input wire logic withdraw,
  input wire logic req_low,
  input wire logic gnt_high,
  // Pins
  input wire logic [NCH-1:0] channel_grant_n,
  output logic [NCH-1:0] channel_request,
  input wire logic [NPC-1:0] pc_grant_n,
  output logic [NPC-1:0] pc_request_n,
  output logic xfer_done
);
  logic [NCH-1:0] req_r;
  logic [NPC-1:0] pc_r;
  logic [3:0] dwell_r;
  logic [NCH-1:0] gnt;
  logic master_n_r;
  logic io_cmd_r;
  logic picked;
  assign gnt = gnt_high ? channel_grant_n : ~channel_grant_n;
  assign channel_request = req_r ^ {NCH{req_low}};
  assign pc_request_n = ~pc_r;
  // Selected by grant and an I/O command together, never by grant alone
  assign picked = ~master_n_r & io_cmd_r;
  always_ff @(posedge clk)
  begin
    if (srst || withdraw)
    begin
      req_r <= '0;
      pc_r <= '0;
      dwell_r <= '0;
      xfer_done <= 1'b0;
      master_n_r <= 1'b1;
      io_cmd_r <= 1'b0;
    end
    else
    begin
      // Requests stay up until granted, then a short transfer
      req_r <= (req_r | want) & ~gnt;
      pc_r <= (pc_r | pc_want) & pc_grant_n;
      // Bus taken only once the grant is seen
      master_n_r <= ~(|gnt);
      io_cmd_r <= ~master_n_r & ~io_cmd_r;
      xfer_done <= (dwell_r == 4'h5) && !xfer_done;
      dwell_r <= (master_n_r || xfer_done) ? 4'h0 : dwell_r + {3'h0, picked};
    end
  end
endmodule
`default_nettype wire

// file: idh_pkg.sv
// Constants, types and helpers shared by the DMA handshake block.
// Assumes a single 25 MHz clock and APB register access.
package idh_pkg;

  // Channel layout: eight slots, slot 4 is the cascade and never serves
  localparam int NCH = 8;
  localparam logic [7:0] CH_MASK = 8'hef;
  localparam int NPC = 3;
  localparam int CLK_MHZ = 25;

  // APB register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_GPO = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_ISR = 8'h0c;
  localparam logic [7:0] OFS_IMR = 8'h10;

  // Command register fields
  localparam int CMD_W = 4;
  localparam int CMD_REQ_LOW = 0;
  localparam int CMD_GNT_HIGH = 1;
  localparam int CMD_PCPCI = 2;
  localparam int CMD_EN = 3;
  localparam logic [3:0] CMD_RST = 4'h8;
  localparam logic [2:0] GPO_RST = 3'h7;

  // Status register fields
  localparam int STAT_CH_LSB = 0;
  localparam int STAT_VALID = 3;
  localparam int STAT_TC = 4;
  localparam int STAT_PCG_LSB = 5;
  localparam int STAT_GPI_LSB = 8;

  // Interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_GRANT = 0;
  localparam int IRQ_TC = 1;
  localparam int IRQ_DROP = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_GRANT = 2'b11,
    ST_DONE = 2'b10
  } idh_state_t;

  // Index of the lowest set bit, zero when none is set
  function automatic logic [2:0] idh_lowest(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

endpackage

// file: idh_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs; output changes only when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module idh_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb
  begin
    q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign dout = q_r;

endmodule
`default_nettype wire

// file: idh_tc.sv
// Terminal count flag towards DMA slaves.
// Assumes engine strobes on the same clock; aen is the address enable level.
`timescale 1ns/10ps
`default_nettype none
module idh_tc
  import idh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Engine side
  input wire logic addr_strobe,
  input wire logic count_expired,
  input wire logic autoinit,
  input wire logic aen,
  input wire logic pos_state,
  // Flag
  output logic terminal_count_flag,
  output logic tc_event
);

  logic tc_r;
  logic tc_nxt;
  logic set;

  always_comb
  begin
    set = addr_strobe & count_expired;
    tc_nxt = tc_r;
    if (pos_state)
      tc_nxt = 1'b0;
    else if (set)
      tc_nxt = 1'b1;
    else if (!aen || autoinit)
      tc_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      tc_r <= 1'b0;
    else
      tc_r <= tc_nxt;
  end

  assign terminal_count_flag = tc_r;
  assign tc_event = set & ~pos_state;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_tc_set;
    addr_strobe && count_expired && !pos_state |=> tc_r;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("tc not set on expiry");

  property p_tc_hold;
    tc_r && aen && !autoinit && !pos_state |=> tc_r;
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("tc dropped while aen high");

  property p_tc_auto;
    tc_r && autoinit && !(addr_strobe && count_expired) |=> !tc_r;
  endproperty
  a_tc_auto: assert property (p_tc_auto) else $error("tc held in autoinit");

  property p_tc_pos;
    pos_state |=> !tc_r;
  endproperty
  a_tc_pos: assert property (p_tc_pos) else $error("tc high in suspend");

endmodule
`default_nettype wire

// file: idh_top.sv
// Request, grant and terminal count handshake of the DMA controller.
// Assumes pins are asynchronous; engine strobes and APB share clk.
// Operation
// - Grant output asserts for a pending DMA request or a bus master.
// - Request and grant active levels are set in the command register.
// - A request withdrawn before its grant is never granted.
// - All grant outputs are high in reset, after it and in suspend.
// - Request edges are asynchronous and synchronised before use.
// - Three active-low PC/PCI request inputs are accepted.
// - Three active-low PC/PCI grant outputs answer those requests.
// - Without PC/PCI the pins act as spare inputs and outputs.
// - PC/PCI grants are high in reset, after it, and suspend-high or spare.
// - Terminal count asserts after an address when the count expires.
// - Terminal count holds until aen drops, or drops first on autoinit.
// - Terminal count is low in reset, after it and in suspend.
`timescale 1ns/10ps
`default_nettype none
module idh_top
  import idh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // ISA channel pins
  input wire logic [NCH-1:0] channel_request,
  output logic [NCH-1:0] channel_grant_n,
  output logic terminal_count_flag,
  // PC/PCI pins
  input wire logic [NPC-1:0] pc_request_n,
  output logic [NPC-1:0] pc_grant_n,
  // Transfer engine
  input wire logic xfer_done,
  input wire logic addr_strobe,
  input wire logic count_expired,
  input wire logic autoinit,
  input wire logic aen,
  output logic grant_valid,
  output logic [2:0] grant_channel,
  // Power state
  input wire logic pos_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NCH-1:0] req_sync;
  logic [NPC-1:0] pc_sync_n;
  logic [NCH-1:0] req_act;
  logic [NPC-1:0] pc_act;
  logic tc_event;

  idh_sync #(.W(NCH), .RST_VAL('0)) u_req_sync (
    .clk(clk),
    .srst(srst),
    .din(channel_request),
    .dout(req_sync)
  );

  idh_sync #(.W(NPC), .RST_VAL('1)) u_pc_sync (
    .clk(clk),
    .srst(srst),
    .din(pc_request_n),
    .dout(pc_sync_n)
  );

  idh_tc u_tc (
    .clk(clk),
    .srst(srst),
    .addr_strobe(addr_strobe),
    .count_expired(count_expired),
    .autoinit(autoinit),
    .aen(aen),
    .pos_state(pos_state),
    .terminal_count_flag(terminal_count_flag),
    .tc_event(tc_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [CMD_W-1:0] cmd_r;
  logic [CMD_W-1:0] cmd_nxt;
  logic [2:0] spare_outputs_9_11_r;
  logic [2:0] spare_outputs_9_11_nxt;
  logic [IRQ_W-1:0] isr_r;
  logic [IRQ_W-1:0] isr_nxt;
  logic [IRQ_W-1:0] imr_r;
  logic [IRQ_W-1:0] imr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;

  // Arbiter state
  idh_state_t st_r;
  idh_state_t st_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic [NCH-1:0] gnt_n_r;
  logic [NCH-1:0] gnt_n_nxt;
  logic ev_grant;
  logic ev_drop;
  logic grant_valid_r;
  logic grant_valid_nxt;

  // PC/PCI state
  logic pc_busy_r;
  logic pc_busy_nxt;
  logic [1:0] pc_sel_r;
  logic [1:0] pc_sel_nxt;
  logic [NPC-1:0] pc_gnt_n_r;
  logic [NPC-1:0] pc_gnt_n_nxt;
  logic [NPC-1:0] pc_onehot;
  logic [2:0] pc_low;

  ////////////////////////////////////////////////////////////////////////////
  // Channel arbiter

  always_comb
  begin
    req_act = (req_sync ^ {NCH{cmd_r[CMD_REQ_LOW]}}) & CH_MASK;
    st_nxt = st_r;
    sel_nxt = sel_r;
    ev_grant = 1'b0;
    ev_drop = 1'b0;
    unique case (st_r)
      ST_IDLE:
      begin
        if (cmd_r[CMD_EN] && (|req_act))
        begin
          sel_nxt = idh_lowest(req_act);
          st_nxt = ST_PEND;
        end
      end
      ST_PEND:
      begin
        if (req_act[sel_r])
        begin
          st_nxt = ST_GRANT;
          ev_grant = 1'b1;
        end
        else
        begin
          st_nxt = ST_IDLE;
          ev_drop = 1'b1;
        end
      end
      ST_GRANT:
      begin
        if (xfer_done)
          st_nxt = ST_DONE;
      end
      ST_DONE:
        st_nxt = ST_IDLE;
    endcase
    if (pos_state)
    begin
      st_nxt = ST_IDLE;
      ev_grant = 1'b0;
    end
    gnt_n_nxt = '0;
    if (st_nxt == ST_GRANT)
      gnt_n_nxt[sel_nxt] = 1'b1;
    if (!cmd_r[CMD_GNT_HIGH])
      gnt_n_nxt = ~gnt_n_nxt;
    if (pos_state)
      gnt_n_nxt = '1;
    grant_valid_nxt = (st_nxt == ST_GRANT);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= ST_IDLE;
      sel_r <= 3'h0;
      gnt_n_r <= '1;
      grant_valid_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      gnt_n_r <= gnt_n_nxt;
      grant_valid_r <= grant_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PC/PCI grants and spare pins

  always_comb
  begin
    pc_act = ~pc_sync_n & {NPC{cmd_r[CMD_PCPCI]}};
    pc_low = idh_lowest({5'h00, pc_act});
    pc_busy_nxt = pc_busy_r;
    pc_sel_nxt = pc_sel_r;
    if (pos_state || !cmd_r[CMD_PCPCI])
      pc_busy_nxt = 1'b0;
    else if (!pc_busy_r && (|pc_act))
    begin
      pc_busy_nxt = 1'b1;
      pc_sel_nxt = pc_low[1:0];
    end
    else if (pc_busy_r && !pc_act[pc_sel_r])
      pc_busy_nxt = 1'b0;
    pc_onehot = '0;
    if (pc_busy_nxt)
      pc_onehot[pc_sel_nxt] = 1'b1;
    if (cmd_r[CMD_PCPCI])
      pc_gnt_n_nxt = pos_state ? '1 : ~pc_onehot;
    else
      pc_gnt_n_nxt = spare_outputs_9_11_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pc_busy_r <= 1'b0;
      pc_sel_r <= 2'h0;
      pc_gnt_n_r <= '1;
    end
    else
    begin
      pc_busy_r <= pc_busy_nxt;
      pc_sel_r <= pc_sel_nxt;
      pc_gnt_n_r <= pc_gnt_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and interrupt

  logic acc;
  logic wr;
  logic [31:0] rd;
  logic [IRQ_W-1:0] ev;

  always_comb
  begin
    acc = psel & penable & pready_r;
    wr = acc & pwrite;
    ev = '0;
    ev[IRQ_GRANT] = ev_grant;
    ev[IRQ_TC] = tc_event;
    ev[IRQ_DROP] = ev_drop;
    cmd_nxt = cmd_r;
    spare_outputs_9_11_nxt = spare_outputs_9_11_r;
    imr_nxt = imr_r;
    isr_nxt = isr_r;
    if (wr && paddr == OFS_CMD)
      cmd_nxt = pwdata[CMD_W-1:0];
    if (wr && paddr == OFS_GPO)
      spare_outputs_9_11_nxt = pwdata[2:0];
    if (wr && paddr == OFS_IMR)
      imr_nxt = pwdata[IRQ_W-1:0];
    if (wr && paddr == OFS_ISR)
      isr_nxt = isr_r & ~pwdata[IRQ_W-1:0];
    isr_nxt = isr_nxt | ev;
    irq_nxt = |(isr_nxt & imr_nxt);
    rd = 32'h0;
    pslverr_nxt = 1'b0;
    unique case (paddr)
      OFS_CMD: rd[CMD_W-1:0] = cmd_r;
      OFS_GPO: rd[2:0] = spare_outputs_9_11_r;
      OFS_STAT:
      begin
        rd[STAT_CH_LSB +: 3] = sel_r;
        rd[STAT_VALID] = (st_r == ST_GRANT);
        rd[STAT_TC] = terminal_count_flag;
        rd[STAT_PCG_LSB +: NPC] = ~pc_gnt_n_r;
        rd[STAT_GPI_LSB +: NPC] = pc_sync_n;
      end
      OFS_ISR: rd[IRQ_W-1:0] = isr_r;
      OFS_IMR: rd[IRQ_W-1:0] = imr_r;
      default: pslverr_nxt = 1'b1;
    endcase
    pready_nxt = psel & penable & ~pready_r;
    prdata_nxt = pready_nxt ? rd : prdata_r;
    if (!pready_nxt)
      pslverr_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_r <= CMD_RST;
      spare_outputs_9_11_r <= GPO_RST;
      isr_r <= '0;
      imr_r <= '0;
      irq_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      cmd_r <= cmd_nxt;
      spare_outputs_9_11_r <= spare_outputs_9_11_nxt;
      isr_r <= isr_nxt;
      imr_r <= imr_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign channel_grant_n = gnt_n_r;
  assign pc_grant_n = pc_gnt_n_r;
  assign grant_valid = grant_valid_r;
  assign grant_channel = sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [NCH-1:0] gnt_act;
  assign gnt_act = cmd_r[CMD_GNT_HIGH] ? gnt_n_r : ~gnt_n_r;

  sequence s_pend_live;
    st_r == ST_PEND && req_act[sel_r] && !pos_state;
  endsequence

  property p_grant_follows;
    s_pend_live |=> gnt_act[sel_r] && $onehot(gnt_act);
  endproperty
  a_grant_follows: assert property (p_grant_follows) else $error("grant missing");

  property p_no_late_grant;
    st_r == ST_PEND && !req_act[sel_r] |=> gnt_act == '0 ##1 st_r != ST_GRANT;
  endproperty
  a_no_late_grant: assert property (p_no_late_grant) else $error("withdrawn granted");

  property p_pos_grant;
    pos_state |=> channel_grant_n == '1;
  endproperty
  a_pos_grant: assert property (p_pos_grant) else $error("grant low in suspend");

  property p_rst_pins;
    disable iff (1'b0) srst |=> channel_grant_n == '1 && pc_grant_n == '1 && !terminal_count_flag;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pin levels");

  property p_sync_delay;
    $changed(req_sync[0]) |-> req_sync[0] == $past(channel_request[0], 4);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("request not synchronised");

  property p_release;
    st_r == ST_GRANT && xfer_done && !pos_state |=> gnt_act == '0 ##1 st_r == ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("grant not released");

  property p_pc_onehot;
    cmd_r[CMD_PCPCI] && $past(cmd_r[CMD_PCPCI]) |-> $onehot0(~pc_grant_n);
  endproperty
  a_pc_onehot: assert property (p_pc_onehot) else $error("two pc grants");

  property p_spare_out;
    !cmd_r[CMD_PCPCI] |=> pc_grant_n == $past(spare_outputs_9_11_r);
  endproperty
  a_spare_out: assert property (p_spare_out) else $error("spare outputs wrong");

  property p_polarity;
    st_r == ST_IDLE && !pos_state && !$past(pos_state) && $past(st_r) == ST_IDLE
      && $stable(cmd_r[CMD_GNT_HIGH]) |-> gnt_act == '0;
  endproperty
  a_polarity: assert property (p_polarity) else $error("idle grant active");

endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the DMA request, grant and terminal count block.
// Assumes the far side model answers requests; engine strobes come from here.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import idh_pkg::*;
  typedef struct {logic [3:0] cmd; int ch; logic [7:0] exp;} idh_row_t;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NCH-1:0] channel_request, channel_grant_n, want;
  logic [NPC-1:0] pc_request_n, pc_grant_n, pc_want;
  logic terminal_count_flag, xfer_done, addr_strobe, count_expired, autoinit, aen;
  logic grant_valid, pos_state, withdraw;
  logic [2:0] grant_channel;
  logic [3:0] cmd;
  int miscompares, check_count;
  idh_row_t rows [7] = '{'{4'h8, 0, 8'hfe}, '{4'ha, 1, 8'h02}, '{4'h9, 2, 8'hfb},
    '{4'hb, 3, 8'h08}, '{4'h8, 5, 8'hdf}, '{4'hb, 6, 8'h40}, '{4'h9, 7, 8'h7f}};
  idh_top uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .channel_request, .channel_grant_n, .terminal_count_flag,
    .pc_request_n, .pc_grant_n, .xfer_done, .addr_strobe, .count_expired, .autoinit,
    .aen, .grant_valid, .grant_channel, .pos_state);
  idh_far_model far (.clk, .srst, .want, .pc_want, .withdraw, .req_low(cmd[0]),
    .gnt_high(cmd[1]), .channel_grant_n, .channel_request, .pc_grant_n, .pc_request_n,
    .xfer_done);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up();
    miscompares++;
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      miscompares++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
      give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Arbiter off while pin polarity settles through the synchronisers
  task automatic set_cmd(input logic [3:0] c);
    apb(1'b1, OFS_CMD, {29'h0, c[2:0]});
    cmd <= c;
    repeat (8) @(posedge clk);
    apb(1'b1, OFS_CMD, {28'h0, c});
  endtask
  task automatic pulse(input logic [7:0] w, input logic [2:0] p, input logic wd);
    @(posedge clk);
    want <= w;
    pc_want <= p;
    withdraw <= wd;
    @(posedge clk);
    want <= '0;
    pc_want <= '0;
    withdraw <= 1'b0;
  endtask
  task automatic wait_for(input logic pc, input logic v);
    int n;
    n = 0;
    while ((pc ? &pc_grant_n : grant_valid) !== v && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 40)
      give_up();
  endtask
  task automatic tc_go();
    @(posedge clk);
    aen <= 1'b1;
    addr_strobe <= 1'b1;
    count_expired <= 1'b1;
    @(posedge clk);
    addr_strobe <= 1'b0;
    count_expired <= 1'b0;
    @(negedge clk);
    chk(32'(terminal_count_flag), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, withdraw, addr_strobe, count_expired, autoinit} = '0;
    {aen, pos_state, paddr, pwdata, want, pc_want} = '0;
    cmd = CMD_RST;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({channel_grant_n, pc_grant_n, terminal_count_flag, irq}, 32'h1ffc);
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk({channel_grant_n, pc_grant_n, terminal_count_flag, irq}, 32'h1ffc);
    apb(1'b0, OFS_CMD, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("done: reset and registers");
    foreach (rows[i])
    begin
      set_cmd(rows[i].cmd);
      pulse(8'h1 << rows[i].ch, 3'h0, 1'b0);
      wait_for(1'b0, 1'b1);
      chk(32'(channel_grant_n), 32'(rows[i].exp));
      chk(32'(grant_channel), 32'(rows[i].ch));
      wait_for(1'b0, 1'b0);
    end
    $display("done: channel rows");
    set_cmd(4'h8);
    pulse(8'h24, 3'h0, 1'b0);
    wait_for(1'b0, 1'b1);
    chk({channel_grant_n, 5'h0, grant_channel}, 32'hfb02);
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    chk({channel_grant_n, 5'h0, grant_channel}, 32'hdf05);
    wait_for(1'b0, 1'b0);
    $display("done: priority");
    set_cmd(4'h0);
    apb(1'b1, OFS_ISR, 32'h7);
    // Two-cycle request; enable lands so that only the idle state sees it
    fork
      begin
        pulse(8'h08, 3'h0, 1'b0);
        pulse(8'h00, 3'h0, 1'b1);
      end
      begin
        repeat (3) @(posedge clk);
        apb(1'b1, OFS_CMD, 32'h8);
      end
    join
    repeat (20)
    begin
      @(negedge clk);
      chk(32'(channel_grant_n), 32'hff);
    end
    apb(1'b0, OFS_ISR, 32'h0);
    chk(32'(rd[IRQ_W-1:0]), 32'h4);
    $display("done: withdrawn request");
    set_cmd(4'hc);
    for (int i = 0; i < NPC; i++)
    begin
      pulse(8'h0, 3'h1 << i, 1'b0);
      wait_for(1'b1, 1'b0);
      chk(32'(pc_grant_n), 32'(3'(~(3'h1 << i))));
      wait_for(1'b1, 1'b1);
    end
    set_cmd(4'h8);
    apb(1'b1, OFS_GPO, 32'h2);
    pulse(8'h0, 3'h2, 1'b0);
    repeat (10) @(posedge clk);
    chk(32'(pc_grant_n), 32'h2);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[10:8]), 32'h5);
    pulse(8'h0, 3'h0, 1'b1);
    apb(1'b1, OFS_GPO, 32'h7);
    $display("done: pc grants and spare pins");
    apb(1'b1, OFS_IMR, 32'h2);
    tc_go();
    repeat (3) @(negedge clk);
    chk({terminal_count_flag, irq}, 32'h3);
    @(posedge clk);
    aen <= 1'b0;
    @(negedge clk);
    chk(32'(terminal_count_flag), 32'h1);
    @(negedge clk);
    chk(32'(terminal_count_flag), 32'h0);
    apb(1'b1, OFS_ISR, 32'h2);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFS_IMR, 32'h0);
    tc_go();
    @(posedge clk);
    autoinit <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk({terminal_count_flag, irq, aen}, 32'h1);
    apb(1'b0, OFS_ISR, 32'h0);
    chk(32'(rd[IRQ_TC]), 32'h1);
    autoinit <= 1'b0;
    apb(1'b1, OFS_ISR, 32'h7);
    $display("done: terminal count and interrupt");
    set_cmd(4'hc);
    pulse(8'h02, 3'h1, 1'b0);
    wait_for(1'b0, 1'b1);
    tc_go();
    @(posedge clk);
    pos_state <= 1'b1;
    repeat (2) @(negedge clk);
    chk({channel_grant_n, pc_grant_n, terminal_count_flag}, 32'hffe);
    @(posedge clk);
    pos_state <= 1'b0;
    aen <= 1'b0;
    pulse(8'h0, 3'h0, 1'b1);
    wait_for(1'b0, 1'b0);
    $display("done: suspend");
    final_report();
  end
endmodule
`default_nettype wire
